// ===== src/serial_status_pkg.sv
// constants for the serial port status, compare and interrupt mask block
package serial_status_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] RECEIVE_COMPARE_A_ADDR      = 32'hFFFBC038;
    localparam logic [31:0] RECEIVE_COMPARE_B_ADDR      = 32'hFFFBC03C;
    localparam logic [31:0] PORT_STATUS_ADDR            = 32'hFFFBC040;
    localparam logic [31:0] INTERRUPT_ENABLE_SET_ADDR   = 32'hFFFBC044;
    localparam logic [31:0] INTERRUPT_ENABLE_CLEAR_ADDR = 32'hFFFBC048;
    localparam logic [31:0] INTERRUPT_MASK_VIEW_ADDR    = 32'hFFFBC04C;

    // widths
    localparam int COMPARE_WIDTH = 16;
    localparam int EVENT_COUNT   = 12;
    localparam int DMA_WIDTH     = 16;

    // status bit positions
    localparam int TX_HOLDING_FREE_BIT        = 0;
    localparam int TX_ALL_SENT_BIT            = 1;
    localparam int TX_DMA_COUNT_DONE_BIT      = 2;
    localparam int TX_DMA_BUFFERS_DRAINED_BIT = 3;
    localparam int RX_WORD_AVAILABLE_BIT      = 4;
    localparam int RX_OVERRUN_FLAG_BIT        = 5;
    localparam int RX_DMA_COUNT_DONE_BIT      = 6;
    localparam int RX_DMA_BUFFERS_DRAINED_BIT = 7;
    localparam int COMPARE_MATCH_A_BIT        = 8;
    localparam int COMPARE_MATCH_B_BIT        = 9;
    localparam int TX_FRAME_SYNC_SEEN_BIT     = 10;
    localparam int RX_FRAME_SYNC_SEEN_BIT     = 11;
    localparam int TRANSMITTER_ON_BIT         = 16;
    localparam int RECEIVER_ON_BIT            = 17;

    // values after reset, and the zero dma count
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [11:0] MASK_RESET    = 12'h000;
    localparam logic [15:0] DMA_ZERO      = 16'h0000;

endpackage : serial_status_pkg

// ===== src/serial_port_status_irq.sv
// status flags, compare values and interrupt mask of a synchronous serial port
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - two read-write 16-bit receive compare values, upper bits read zero
// - status bit 0 is 1 when the transmit holding register is empty
// - status bit 1 is 1 once last word fully shifted out
// - status bit 2 sets at transmit count zero, clears on count writes
// - status bit 3 is 1 when both transmit counters are zero
// - status bit 4 is 1 while a received word waits in holding register
// - status bit 5 sets on receive overwrite, clears on status read
// - status bit 6 sets at receive count zero, clears on count writes
// - status bit 7 is 1 when both receive counters are zero
// - status bit 8 sets on first compare match, clears on status read
// - status bit 9 sets on second compare match, clears on status read
// - status bit 10 sets on transmit frame sync, clears on status read
// - status bit 11 sets on receive frame sync, clears on status read
// - status bits 16 and 17 show transmitter and receiver enabled
// - write-only enable register sets mask bits where ones written
// - write-only disable register clears mask bits where ones written
// - mask register reads back enabled sources at status bit positions
// - edge select 0 takes rising frame sync edge, 1 takes falling
module serial_port_status_irq
(
    input  wire logic                                   clk_in,
    input  wire logic                                   reset_n_in,
    // avalon-mm slave
    input  wire logic [31:0]                            address_in,
    input  wire logic                                   read_in,
    input  wire logic                                   write_in,
    input  wire logic [31:0]                            writedata_in,
    output logic [31:0]                                 readdata_out,
    output logic                                        waitrequest_out,
    // transmit datapath strobes
    input  wire logic                                   tx_holding_write_in,
    input  wire logic                                   tx_holding_to_shift_in,
    input  wire logic                                   tx_shift_done_in,
    // receive datapath strobes
    input  wire logic                                   rx_holding_load_in,
    input  wire logic                                   rx_holding_read_in,
    // peripheral dma counters and their write strobes
    input  wire logic [serial_status_pkg::DMA_WIDTH-1:0] tx_dma_count_in,
    input  wire logic [serial_status_pkg::DMA_WIDTH-1:0] tx_dma_next_count_in,
    input  wire logic                                   tx_dma_count_write_in,
    input  wire logic [serial_status_pkg::DMA_WIDTH-1:0] rx_dma_count_in,
    input  wire logic [serial_status_pkg::DMA_WIDTH-1:0] rx_dma_next_count_in,
    input  wire logic                                   rx_dma_count_write_in,
    // events and levels from the rest of the port
    input  wire logic                                   compare_match_a_in,
    input  wire logic                                   compare_match_b_in,
    input  wire logic                                   tx_frame_sync_pin_in,
    input  wire logic                                   sync_edge_select_in,
    input  wire logic                                   rx_sync_event_in,
    input  wire logic                                   transmitter_on_in,
    input  wire logic                                   receiver_on_in,
    // outputs
    output logic [serial_status_pkg::COMPARE_WIDTH-1:0] compare_a_out,
    output logic [serial_status_pkg::COMPARE_WIDTH-1:0] compare_b_out,
    output logic                                        irq_out
);
    import serial_status_pkg::*;

    // overview of the block:
    // - one bus slave, no buffering
    // - every access takes one wait cycle
    // - reads captured at the first edge
    // - writes land at the second edge
    // - read-cleared flags drop at the
    //   capture edge, so the value that
    //   software sees is the one cleared
    // - an event in that same cycle wins
    //   and shows on the following read
    // - level flags follow their inputs
    //   with no register in between
    // - sticky flags hold until cleared
    // - only the frame sync pin is async
    // - all other strobes share clk_in
    // limitation: no byte enables, whole
    // words only; narrow writes would
    // need a merge in front of this block
    // trade-off: fixed wait cycle keeps
    // the read path registered and short

    logic                     ack;
    logic                     access_go;
    logic                     read_go;
    logic                     write_go;
    logic                     status_read;
    logic                     tx_holding_full;
    logic                     tx_shift_busy;
    logic                     rx_holding_full;
    logic [EVENT_COUNT-1:0]   sticky;
    logic [EVENT_COUNT-1:0]   status_low;
    logic [EVENT_COUNT-1:0]   mask;
    logic [31:0]              status_word;
    logic [31:0]              next_readdata;
    logic                     sync_meta;
    logic                     sync_stable;
    logic                     sync_prev;
    logic                     tx_sync_event;
    logic                     tx_dma_drained;
    logic                     rx_dma_drained;

    // bus handshake notes:
    // - ack is high only in the second
    //   cycle of a request
    // - waitrequest drops while ack is up
    // - the master must hold its request
    //   until it sees waitrequest low
    // - dropping early loses the write
    //   but a read is already captured
    // - read_go marks the capture edge
    // - write_go marks the commit edge
    // hazard: a read that ends before its
    // second cycle still clears the
    // read-sensitive flags
    // every access waits one cycle; the read data is captured on the first edge
    assign waitrequest_out = (read_in | write_in) & ~ack;
    assign access_go       = (read_in | write_in) & ~ack;
    assign read_go         = read_in & ~ack;
    assign write_go        = write_in & ack;
    assign status_read     = read_go & (address_in == PORT_STATUS_ADDR);

    // one-cycle acknowledge, so back-to-back requests each wait again
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= access_go;
        end
    end

    // compare registers:
    // - only bits 15:0 are stored
    // - upper write bits are dropped
    // - reads return zero above bit 15
    // - both feed the match logic outside
    // - a write here never raises a match
    //   by itself; the outside logic does
    // limitation: no protection against a
    // match racing a compare update
    // compare values steer the external match logic
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            compare_a_out <= COMPARE_RESET;
            compare_b_out <= COMPARE_RESET;
        end else if (write_go) begin
            if (address_in == RECEIVE_COMPARE_A_ADDR) begin
                compare_a_out <= writedata_in[COMPARE_WIDTH-1:0];
            end
            if (address_in == RECEIVE_COMPARE_B_ADDR) begin
                compare_b_out <= writedata_in[COMPARE_WIDTH-1:0];
            end
        end
    end

    // interrupt mask:
    // - set and clear use two addresses
    // - ones act, zeros leave bits alone
    // - no read-modify-write is needed
    // - only bits 11:0 exist
    // - the view register reads it back
    // why: separate set and clear let
    // two drivers touch different bits
    // without losing each other's update
    // mask set and clear through separate write-only registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask <= MASK_RESET;
        end else if (write_go) begin
            if (address_in == INTERRUPT_ENABLE_SET_ADDR) begin
                mask <= mask | writedata_in[EVENT_COUNT-1:0];
            end else if (address_in == INTERRUPT_ENABLE_CLEAR_ADDR) begin
                mask <= mask & ~writedata_in[EVENT_COUNT-1:0];
            end
        end
    end

    // transmit occupancy:
    // - holding full after a data write
    // - emptied when the word moves on
    // - shifter busy from the move until
    //   the shift-done strobe
    // - all sent needs both to be idle
    // hazard: a write and a move in one
    // cycle mean a new word arrived as
    // the old one left, so full stays
    // limitation: the shifter's own bit
    // count lives outside this block
    // transmit holding and shift occupancy; a fresh write wins over the move
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_holding_full <= 1'b0;
            tx_shift_busy   <= 1'b0;
        end else begin
            if (tx_holding_write_in) begin
                tx_holding_full <= 1'b1;
            end else if (tx_holding_to_shift_in) begin
                tx_holding_full <= 1'b0;
            end
            if (tx_holding_to_shift_in) begin
                tx_shift_busy <= 1'b1;
            end else if (tx_shift_done_in) begin
                tx_shift_busy <= 1'b0;
            end
        end
    end

    // receive occupancy:
    // - set by a load from the shifter
    // - cleared by a software read
    // - a load and a read together mean
    //   a fresh word, so it stays full
    // - overrun is judged on this flag
    // receive holding occupancy; a load in the read cycle keeps it full
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_holding_full <= 1'b0;
        end else if (rx_holding_load_in) begin
            rx_holding_full <= 1'b1;
        end else if (rx_holding_read_in) begin
            rx_holding_full <= 1'b0;
        end
    end

    // frame sync edge detection:
    // - two flops take the pin into clk_in
    // - a third keeps the previous level
    // - edge select picks rise or fall
    // - all reset low to match an idle
    //   low pin, so no edge after reset
    // - pulses shorter than one clock
    //   may be missed; that is accepted
    // - the event shows two edges late
    // limitation: a pin held high through
    // reset gives one rising event
    // frame sync pin comes from outside, so two flops before the edge logic
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_meta   <= 1'b0;
            sync_stable <= 1'b0;
            sync_prev   <= 1'b0;
        end else begin
            sync_meta   <= tx_frame_sync_pin_in;
            sync_stable <= sync_meta;
            sync_prev   <= sync_stable;
        end
    end

    assign tx_sync_event = sync_edge_select_in ? (sync_prev & ~sync_stable)
                                               : (~sync_prev & sync_stable);
    assign tx_dma_drained = (tx_dma_count_in == DMA_ZERO) && (tx_dma_next_count_in == DMA_ZERO);
    assign rx_dma_drained = (rx_dma_count_in == DMA_ZERO) && (rx_dma_next_count_in == DMA_ZERO);

    // sticky flag notes:
    // - read-cleared: overrun, both
    //   matches, both frame syncs
    // - count-cleared: both dma done
    // - dma done is set while the count
    //   is zero, so a counter write with
    //   a zero count leaves it set
    // - overrun: load while full and no
    //   read in the same cycle
    // - slots 0,1,3,4,7 are level bits
    //   and are overlaid in status_low
    // why: later nonblocking writes win,
    // so the set terms go last
    // sticky flags: the set term is applied last so an event never gets lost
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sticky <= '0;
        end else begin
            if (status_read) begin
                sticky[RX_OVERRUN_FLAG_BIT]    <= 1'b0;
                sticky[COMPARE_MATCH_A_BIT]    <= 1'b0;
                sticky[COMPARE_MATCH_B_BIT]    <= 1'b0;
                sticky[TX_FRAME_SYNC_SEEN_BIT] <= 1'b0;
                sticky[RX_FRAME_SYNC_SEEN_BIT] <= 1'b0;
            end
            if (tx_dma_count_write_in) begin
                sticky[TX_DMA_COUNT_DONE_BIT] <= 1'b0;
            end
            if (rx_dma_count_write_in) begin
                sticky[RX_DMA_COUNT_DONE_BIT] <= 1'b0;
            end
            if (tx_dma_count_in == DMA_ZERO) begin
                sticky[TX_DMA_COUNT_DONE_BIT] <= 1'b1;
            end
            if (rx_dma_count_in == DMA_ZERO) begin
                sticky[RX_DMA_COUNT_DONE_BIT] <= 1'b1;
            end
            if (rx_holding_load_in && rx_holding_full && !rx_holding_read_in) begin
                sticky[RX_OVERRUN_FLAG_BIT] <= 1'b1;
            end
            if (compare_match_a_in) begin
                sticky[COMPARE_MATCH_A_BIT] <= 1'b1;
            end
            if (compare_match_b_in) begin
                sticky[COMPARE_MATCH_B_BIT] <= 1'b1;
            end
            if (tx_sync_event) begin
                sticky[TX_FRAME_SYNC_SEEN_BIT] <= 1'b1;
            end
            if (rx_sync_event_in) begin
                sticky[RX_FRAME_SYNC_SEEN_BIT] <= 1'b1;
            end
        end
    end

    // status word layout:
    // - bits 11:0 are event and level
    //   flags, same order as the mask
    // - bits 17:16 are the enables
    // - reserved bits read zero
    // - levels are live, not registered
    // live status view; the unused sticky slots stay at zero
    always_comb begin
        status_low                             = sticky;
        status_low[TX_HOLDING_FREE_BIT]        = ~tx_holding_full;
        status_low[TX_ALL_SENT_BIT]            = ~tx_holding_full & ~tx_shift_busy;
        status_low[TX_DMA_BUFFERS_DRAINED_BIT] = tx_dma_drained;
        status_low[RX_WORD_AVAILABLE_BIT]      = rx_holding_full;
        status_low[RX_DMA_BUFFERS_DRAINED_BIT] = rx_dma_drained;
        status_word                            = '0;
        status_word[EVENT_COUNT-1:0]           = status_low;
        status_word[TRANSMITTER_ON_BIT]        = transmitter_on_in;
        status_word[RECEIVER_ON_BIT]           = receiver_on_in;
    end

    // read mux notes:
    // - full 32-bit address compare
    // - no error response is given
    // - write-only registers read zero
    // read mux; write-only and unmapped addresses read as zero
    always_comb begin
        next_readdata = '0;
        unique case (address_in)
            RECEIVE_COMPARE_A_ADDR:   next_readdata[COMPARE_WIDTH-1:0] = compare_a_out;
            RECEIVE_COMPARE_B_ADDR:   next_readdata[COMPARE_WIDTH-1:0] = compare_b_out;
            PORT_STATUS_ADDR:         next_readdata = status_word;
            INTERRUPT_MASK_VIEW_ADDR: next_readdata[EVENT_COUNT-1:0] = mask;
            default:                  next_readdata = '0;
        endcase
    end

    // read data captured at the edge that also clears the read-sensitive flags
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            readdata_out <= '0;
        end else if (read_go) begin
            readdata_out <= next_readdata;
        end
    end

    // interrupt output:
    // - any flag with its mask bit set
    // - level bits count as sources too
    // - clears one cycle after the cause
    // trade-off: one cycle of latency
    // buys a clean level for the pin
    // registered interrupt, one cycle behind the flags to keep it glitch free
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_low & mask);
        end
    end

endmodule // serial_port_status_irq

`default_nettype wire

// ===== test/serial_status_monitor.sv
// assertions on bus timing, compare values and status read-back
`timescale 1ns/1ns
`default_nettype none
module serial_status_monitor
    import serial_status_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [31:0] address_in,
    input wire logic        read_in,
    input wire logic        write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [31:0] readdata_out,
    input wire logic        waitrequest_out,
    input wire logic [15:0] tx_dma_count_in,
    input wire logic [15:0] tx_dma_next_count_in,
    input wire logic [15:0] rx_dma_count_in,
    input wire logic [15:0] rx_dma_next_count_in,
    input wire logic        transmitter_on_in,
    input wire logic        receiver_on_in,
    input wire logic [15:0] compare_a_out,
    input wire logic [15:0] compare_b_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // read capture edge and write commit edge
    wire logic cap = read_in && waitrequest_out;
    wire logic wr = write_in && !waitrequest_out;
    wire logic st = cap && address_in == PORT_STATUS_ADDR;
    wire logic [15:0] wd = writedata_in[15:0];
    // levels only checked when steady, the flags may be registered
    wire logic [3:0] lv = {receiver_on_in, transmitter_on_in,
        rx_dma_count_in == 16'h0000 && rx_dma_next_count_in == 16'h0000,
        tx_dma_count_in == 16'h0000 && tx_dma_next_count_in == 16'h0000};

    a_wait_first: assert property ($rose(read_in || write_in) |-> waitrequest_out)
        else $error("request answered without wait");
    a_wait_once: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("more than one wait cycle");
    a_cmp_a_wr: assert property (wr && address_in == RECEIVE_COMPARE_A_ADDR |=> compare_a_out == $past(wd))
        else $error("compare a not written");
    a_cmp_b_wr: assert property (wr && address_in == RECEIVE_COMPARE_B_ADDR |=> compare_b_out == $past(wd))
        else $error("compare b not written");
    a_cmp_hold: assert property (!(wr && (address_in == RECEIVE_COMPARE_A_ADDR || address_in == RECEIVE_COMPARE_B_ADDR))
        |=> $stable({compare_a_out, compare_b_out}))
        else $error("compare value changed without write");
    a_cmp_read: assert property (cap && address_in == RECEIVE_COMPARE_A_ADDR
        |=> readdata_out == {16'h0000, compare_a_out})
        else $error("compare a read back wrong");
    a_status_lv: assert property (st && $stable(lv)
        |=> {readdata_out[17:16], readdata_out[7], readdata_out[3]} == $past(lv))
        else $error("status levels wrong");
    a_status_rsv: assert property (st |=> readdata_out[31:18] == 14'h0000 && readdata_out[15:12] == 4'h0)
        else $error("status reserved bits set");
    a_mask_rsv: assert property (cap && address_in == INTERRUPT_MASK_VIEW_ADDR
        |=> readdata_out[31:12] == 20'h00000)
        else $error("mask reserved bits set");

    c_status_read: cover property (st);
    c_mask_set: cover property (wr && address_in == INTERRUPT_ENABLE_SET_ADDR);
    c_cmp_write: cover property (wr && address_in == RECEIVE_COMPARE_B_ADDR);
endmodule // serial_status_monitor

bind serial_port_status_irq serial_status_monitor u_serial_status_monitor (.*);
`default_nettype wire

// ===== test/serial_port_status_irq_tb.sv
// self-checking bench for the serial port status block
`timescale 1ns/1ns
`default_nettype none
module serial_port_status_irq_tb;
    import serial_status_pkg::*;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [31:0] address_in = '0, writedata_in = '0, readdata_out, rd, d, c;
    logic        read_in = 1'b0, write_in = 1'b0, waitrequest_out, irq_out;
    logic [9:0]  ev = '0; // one strobe per event input
    logic [15:0] tx_cnt = '0, tx_nxt = '0, rx_cnt = '0, rx_nxt = '0, cmp_a, cmp_b;
    logic        pin = 1'b0, edge_sel = 1'b0, tx_on = 1'b0, rx_on = 1'b0;
    logic [11:0] m = '0;
    int          err_total = 0, compares = 0;

    always #50 clk_in = ~clk_in;

    serial_port_status_irq u_serial_port_status_irq (.clk_in, .reset_n_in, .address_in, .read_in,
        .write_in, .writedata_in, .readdata_out, .waitrequest_out, .tx_holding_write_in(ev[0]),
        .tx_holding_to_shift_in(ev[1]), .tx_shift_done_in(ev[2]), .rx_holding_load_in(ev[3]),
        .rx_holding_read_in(ev[4]), .tx_dma_count_in(tx_cnt), .tx_dma_next_count_in(tx_nxt),
        .tx_dma_count_write_in(ev[8]), .rx_dma_count_in(rx_cnt), .rx_dma_next_count_in(rx_nxt),
        .rx_dma_count_write_in(ev[9]), .compare_match_a_in(ev[5]), .compare_match_b_in(ev[6]),
        .tx_frame_sync_pin_in(pin), .sync_edge_select_in(edge_sel), .rx_sync_event_in(ev[7]),
        .transmitter_on_in(tx_on), .receiver_on_in(rx_on), .compare_a_out(cmp_a),
        .compare_b_out(cmp_b), .irq_out);

    function automatic logic [31:0] exp_st(input logic [11:0] f);
        return {14'h0000, rx_on, tx_on, 4'h0, f};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one transfer; request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        address_in <= a;
        writedata_in <= wd;
        write_in <= w;
        read_in <= !w;
        do begin
            @(posedge clk_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 40);
        rd = readdata_out;
        if (waitrequest_out !== 1'b0) begin
            err_total++;
            $display("MISMATCH %0t bus wait timeout", $time);
            results();
        end
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge clk_in); // lets the release land before the next request
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h00000000);
        chk(rd, exp, msg);
    endtask

    task automatic pulse(input logic [9:0] v);
        ev <= v;
        @(posedge clk_in);
        ev <= '0;
        @(posedge clk_in);
    endtask

    task automatic irq_is(input logic e, input string msg);
        repeat (3) @(posedge clk_in);
        chk({31'h0, irq_out}, {31'h0, e}, msg);
    endtask

    initial begin
        d = $urandom(15);
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "reset status");
        // compare values, upper half reads zero
        for (int i = 0; i < 4; i++) begin
            d = $urandom();
            c = $urandom();
            bus(1'b1, RECEIVE_COMPARE_A_ADDR, d);
            bus(1'b1, RECEIVE_COMPARE_B_ADDR, c);
            rdchk(RECEIVE_COMPARE_A_ADDR, {16'h0000, d[15:0]}, "cmp a");
            rdchk(RECEIVE_COMPARE_B_ADDR, {16'h0000, c[15:0]}, "cmp b");
        end
        bus(1'b1, PORT_STATUS_ADDR, 32'hFFFFFFFF);
        chk({cmp_a, cmp_b}, {d[15:0], c[15:0]}, "cmp outs");
        rdchk(32'hFFFBC050, 32'h00000000, "unmapped");
        $display("end compare");
        // mask set and clear, last pass clears all
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            c = (i == 7) ? 32'hFFFFFFFF : $urandom();
            bus(1'b1, INTERRUPT_ENABLE_SET_ADDR, d);
            m = m | d[11:0];
            rdchk(INTERRUPT_MASK_VIEW_ADDR, {20'h00000, m}, "mask set");
            bus(1'b1, INTERRUPT_ENABLE_CLEAR_ADDR, c);
            m = m & ~c[11:0];
            rdchk(INTERRUPT_MASK_VIEW_ADDR, {20'h00000, m}, "mask clr");
        end
        $display("end mask");
        irq_is(1'b0, "irq idle");
        bus(1'b1, INTERRUPT_ENABLE_SET_ADDR, 32'h00000100);
        irq_is(1'b0, "irq no match");
        pulse(10'h020);
        irq_is(1'b1, "irq match");
        rdchk(PORT_STATUS_ADDR, exp_st(12'h1CF), "match a");
        irq_is(1'b0, "irq read clr");
        bus(1'b1, INTERRUPT_ENABLE_SET_ADDR, 32'h00000001);
        irq_is(1'b1, "irq level");
        bus(1'b1, INTERRUPT_ENABLE_CLEAR_ADDR, 32'h00000101);
        irq_is(1'b0, "irq masked");
        $display("end irq");
        // sticky events, overrun and frame sync edges
        pin <= 1'b1;
        repeat (6) @(posedge clk_in);
        pulse(10'h0E8);
        pulse(10'h008);
        rdchk(PORT_STATUS_ADDR, exp_st(12'hFFF), "sticky set");
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0DF), "sticky clr");
        pulse(10'h010);
        pin <= 1'b0;
        repeat (6) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "fall sel0");
        edge_sel <= 1'b1;
        pin <= 1'b1;
        repeat (6) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "rise sel1");
        pin <= 1'b0;
        repeat (6) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h4CF), "fall sel1");
        $display("end events");
        // transmit holding and shifter
        pulse(10'h001);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CC), "tx written");
        pulse(10'h002);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CD), "tx shifting");
        pulse(10'h004);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "tx sent");
        // dma counters: nonzero write clears, zero sets
        tx_cnt <= 16'($urandom_range(65535, 1));
        rx_cnt <= 16'($urandom_range(65535, 1));
        rx_nxt <= 16'($urandom_range(65535, 1));
        pulse(10'h300);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h003), "dma busy");
        tx_cnt <= '0;
        rx_cnt <= '0;
        repeat (2) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h04F), "dma zero");
        rx_nxt <= '0;
        repeat (2) @(posedge clk_in);
        rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "dma drained");
        $display("end tx dma");
        for (int i = 0; i < 4; i++) begin
            {rx_on, tx_on} <= 2'(i);
            @(posedge clk_in);
            rdchk(PORT_STATUS_ADDR, exp_st(12'h0CF), "enables");
        end
        $display("end enables");
        results();
    end
endmodule // serial_port_status_irq_tb
`default_nettype wire
